// >>> hdl/ccu_pkg.sv
// Shared constants, mode codes and decode helpers of the capture/compare unit
package ccu_pkg;

	// Register port geometry and offsets
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam logic [1:0] OFF_CONTROL = 2'h0;
	localparam logic [1:0] OFF_LOW = 2'h1;
	localparam logic [1:0] OFF_HIGH = 2'h2;

	// Reset values
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Field positions inside unit_control
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 3;
	localparam int DUTY_LSB = 4;
	localparam int DUTY_MSB = 5;
	localparam int CTRL_IMPL_MSB = 5;

	// Prescaler terminal counts for the divided capture modes
	localparam logic [3:0] PS4_LAST = 4'h3;
	localparam logic [3:0] PS16_LAST = 4'hf;
	localparam logic [3:0] PS_CLEAR = 4'h0;

	// Mode codes; every 11xx code is PWM
	typedef enum logic [3:0] {
		MODE_OFF = 4'b0000,
		MODE_RSV_1 = 4'b0001,
		MODE_CMP_TOGGLE = 4'b0010,
		MODE_RSV_3 = 4'b0011,
		MODE_CAP_FALL = 4'b0100,
		MODE_CAP_RISE = 4'b0101,
		MODE_CAP_RISE4 = 4'b0110,
		MODE_CAP_RISE16 = 4'b0111,
		MODE_CMP_SET = 4'b1000,
		MODE_CMP_CLEAR = 4'b1001,
		MODE_CMP_SOFT = 4'b1010,
		MODE_RSV_B = 4'b1011,
		MODE_PWM = 4'b1100
	} ccu_mode_t;

	// Capture modes are 01xx
	function automatic logic ccu_is_capture(input logic [3:0] m);
		ccu_is_capture = (m[3:2] == 2'b01);
	endfunction

	// PWM modes are 11xx
	function automatic logic ccu_is_pwm(input logic [3:0] m);
		ccu_is_pwm = (m[3:2] == 2'b11);
	endfunction

	// Compare modes that watch the timer
	function automatic logic ccu_is_compare(input logic [3:0] m);
		ccu_is_compare = (m == MODE_CMP_TOGGLE) || (m == MODE_CMP_SET) ||
			(m == MODE_CMP_CLEAR) || (m == MODE_CMP_SOFT);
	endfunction

	// Compare modes that own the pin
	function automatic logic ccu_drives_pin(input logic [3:0] m);
		ccu_drives_pin = (m == MODE_CMP_TOGGLE) || (m == MODE_CMP_SET) ||
			(m == MODE_CMP_CLEAR);
	endfunction

endpackage

// >>> hdl/ccu_cap_if.sv
// Link between the unit core and its capture edge prescaler
`timescale 1ns/1ps
interface ccu_cap_if;
	logic pin_level;
	logic [3:0] mode;
	logic capture_evt;

	modport core (
		output pin_level,
		output mode,
		input capture_evt
	);

	modport pre (
		input pin_level,
		input mode,
		output capture_evt
	);
endinterface

// >>> hdl/ccu_capture_prescaler.sv
// Pin synchroniser, edge detector and capture prescaler
`timescale 1ns/1ps
module ccu_capture_prescaler (
	input wire logic clock,
	input wire logic rst_n,
	ccu_cap_if.pre cap
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [3:0] count;
		logic evt;
	} ccu_pre_state_t;

	ccu_pre_state_t s_q;
	ccu_pre_state_t s_d;
	logic rise;
	logic fall;

	// Edges are taken only from the second stage, never the first
	always_comb begin
		s_d = s_q;
		s_d.sync1 = cap.pin_level;
		s_d.sync2 = s_q.sync1;
		s_d.prev = s_q.sync2;
		rise = s_q.sync2 & ~s_q.prev;
		fall = ~s_q.sync2 & s_q.prev;
		s_d.evt = 1'b0;
		if (!ccu_pkg::ccu_is_capture(cap.mode)) begin
			// Off, compare, PWM and reserved codes hold the count at zero
			s_d.count = ccu_pkg::PS_CLEAR;
		end else begin
			// Code changes inside capture keep the count: a stale count
			// can fire the first capture early
			case (cap.mode)
				ccu_pkg::MODE_CAP_FALL: begin
					s_d.evt = fall;
				end
				ccu_pkg::MODE_CAP_RISE: begin
					s_d.evt = rise;
				end
				ccu_pkg::MODE_CAP_RISE4: begin
					if (rise) begin
						if (s_q.count >= ccu_pkg::PS4_LAST) begin
							s_d.count = ccu_pkg::PS_CLEAR;
							s_d.evt = 1'b1;
						end else begin
							s_d.count = s_q.count + 4'h1;
						end
					end
				end
				ccu_pkg::MODE_CAP_RISE16: begin
					if (rise) begin
						if (s_q.count == ccu_pkg::PS16_LAST) begin
							s_d.count = ccu_pkg::PS_CLEAR;
							s_d.evt = 1'b1;
						end else begin
							s_d.count = s_q.count + 4'h1;
						end
					end
				end
				default: begin
					s_d.evt = 1'b0;
				end
			endcase
		end
	end

	// State register, cleared by reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign cap.capture_evt = s_q.evt;

endmodule

// >>> hdl/ccu_unit.sv
// Capture/compare/PWM unit core with register port and pin logic
//
// Contract
// - Mode 0000 stops everything, clears compare latch and prescaler; data and flag keep their values
// - Codes 0100-0111 pick falling, rising, 4th, 16th edge
// - Mode 0010 toggles output on match, sets flag
// - Mode 1000 starts low, match forces high
// - Mode 1001 starts high, match forces low
// - Mode 1010 only flags; pin follows port latch
// - Mode 11xx is PWM; duty from byte, bits
// - Control bits 7 and 6 read zero
// - Control and both data bytes read/write
// - Capture/compare use 16-bit timer, PWM 8-bit
// - Units of one class may share timer
// - Capture copies full 16-bit timer count
// - Every capture sets flag until software clears
// - New capture overwrites unread data
// - Prescaler cleared outside capture and on reset
// - Capture code switch keeps prescaler count
// - Pin sampled even while driven as output
// - Compare every cycle; act and flag together
// - Writing zero to control clears compare latch
`timescale 1ns/1ps
module ccu_unit (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] timer_one_count,
	input wire logic [15:0] timer_three_count,
	input wire logic cc_use_timer_three,
	input wire logic [7:0] pwm_timer_two_count,
	input wire logic [7:0] pwm_timer_four_count,
	input wire logic pwm_use_timer_four,
	input wire logic flag_clear,
	output logic unit_event_flag,
	output logic compare_match,
	input wire logic event_pin_in,
	input wire logic port_latch,
	input wire logic pin_dir_output,
	output logic event_pin_out,
	output logic event_pin_oe,
	output logic pwm_active,
	output logic [9:0] pwm_duty,
	output logic [7:0] pwm_timebase
);

	typedef struct packed {
		logic [5:0] control;
		logic [15:0] data;
		logic cmp_latch;
		logic flag;
		logic match;
		logic [7:0] rdata;
		logic pwm_on;
		logic [9:0] duty;
		logic [7:0] pwm_base;
	} ccu_state_t;

	ccu_state_t s_q;
	ccu_state_t s_d;
	logic [3:0] mode;
	logic [3:0] new_mode;
	logic [15:0] cc_timer;
	logic [7:0] pwm_timer;
	logic match_now;
	logic ctrl_wr;
	logic set_flag;

	ccu_cap_if cap_link ();

	// Edge capture runs in its own small module
	ccu_capture_prescaler u_prescaler (
		.clock(clock),
		.rst_n(rst_n),
		.cap(cap_link.pre)
	);

	// Pin goes to the prescaler even when this unit drives it, so a
	// port write can cause a capture
	assign cap_link.pin_level = event_pin_in;
	assign cap_link.mode = s_q.control[ccu_pkg::MODE_MSB:ccu_pkg::MODE_LSB];

	// Timer selection comes from outside; several units may point at
	// the same counter, nothing here assumes exclusive use
	assign cc_timer = cc_use_timer_three ? timer_three_count :
		timer_one_count;
	assign pwm_timer = pwm_use_timer_four ? pwm_timer_four_count :
		pwm_timer_two_count;

	assign mode = s_q.control[ccu_pkg::MODE_MSB:ccu_pkg::MODE_LSB];
	assign new_mode = reg_wdata[ccu_pkg::MODE_MSB:ccu_pkg::MODE_LSB];
	assign ctrl_wr = reg_write && (reg_addr == ccu_pkg::OFF_CONTROL);

	// Equality check every cycle; reserved and off codes never match
	assign match_now = ccu_pkg::ccu_is_compare(mode) &&
		(s_q.data == cc_timer);

	// Next-state logic
	always_comb begin
		s_d = s_q;
		set_flag = 1'b0;
		s_d.match = match_now;

		// Compare action on the old latch value; flag in the same cycle
		if (match_now) begin
			set_flag = 1'b1;
			case (mode)
				ccu_pkg::MODE_CMP_TOGGLE: begin
					s_d.cmp_latch = ~s_q.cmp_latch;
				end
				ccu_pkg::MODE_CMP_SET: begin
					s_d.cmp_latch = 1'b1;
				end
				ccu_pkg::MODE_CMP_CLEAR: begin
					s_d.cmp_latch = 1'b0;
				end
				default: begin
					s_d.cmp_latch = s_q.cmp_latch;
				end
			endcase
		end

		// Control write; the initial pin level is set on mode entry only
		if (ctrl_wr) begin
			s_d.control = reg_wdata[ccu_pkg::CTRL_IMPL_MSB:0];
			if (new_mode == ccu_pkg::MODE_OFF) begin
				s_d.cmp_latch = 1'b0;
			end else if (new_mode != mode) begin
				case (new_mode)
					ccu_pkg::MODE_CMP_SET: begin
						s_d.cmp_latch = 1'b0;
					end
					ccu_pkg::MODE_CMP_CLEAR: begin
						s_d.cmp_latch = 1'b1;
					end
					default: begin
						s_d.cmp_latch = s_d.cmp_latch;
					end
				endcase
			end
		end else if (mode == ccu_pkg::MODE_OFF) begin
			// Disabled unit keeps its latch at the reset level
			s_d.cmp_latch = 1'b0;
		end

		// Data bytes by software
		if (reg_write && (reg_addr == ccu_pkg::OFF_LOW)) begin
			s_d.data[7:0] = reg_wdata;
		end
		if (reg_write && (reg_addr == ccu_pkg::OFF_HIGH)) begin
			s_d.data[15:8] = reg_wdata;
		end

		// Capture wins over a software write in the same cycle, and
		// never waits for the old value to be read
		if (cap_link.capture_evt &&
			ccu_pkg::ccu_is_capture(mode)) begin
			s_d.data = cc_timer;
			set_flag = 1'b1;
		end

		// Sticky flag; a new event beats a clear in the same cycle
		if (flag_clear) begin
			s_d.flag = 1'b0;
		end
		if (set_flag) begin
			s_d.flag = 1'b1;
		end

		// Read data valid only in the cycle after the strobe
		s_d.rdata = ccu_pkg::READ_IDLE;
		if (reg_read) begin
			case (reg_addr)
				ccu_pkg::OFF_CONTROL: begin
					s_d.rdata = {2'b00, s_q.control};
				end
				ccu_pkg::OFF_LOW: begin
					s_d.rdata = s_q.data[7:0];
				end
				ccu_pkg::OFF_HIGH: begin
					s_d.rdata = s_q.data[15:8];
				end
				default: begin
					s_d.rdata = ccu_pkg::READ_IDLE;
				end
			endcase
		end

		// PWM hand-off: duty and time base for the waveform stage
		s_d.pwm_on = ccu_pkg::ccu_is_pwm(mode);
		if (ccu_pkg::ccu_is_pwm(mode)) begin
			s_d.duty = {s_q.data[7:0],
				s_q.control[ccu_pkg::DUTY_MSB:ccu_pkg::DUTY_LSB]};
			s_d.pwm_base = pwm_timer;
		end else begin
			s_d.duty = 10'h000;
			s_d.pwm_base = 8'h00;
		end
	end

	// State register; data bytes reset to zero for determinism
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q.control <= ccu_pkg::CONTROL_RESET;
			s_q.data <= ccu_pkg::DATA_RESET;
			s_q.cmp_latch <= 1'b0;
			s_q.flag <= 1'b0;
			s_q.match <= 1'b0;
			s_q.rdata <= ccu_pkg::READ_IDLE;
			s_q.pwm_on <= 1'b0;
			s_q.duty <= 10'h000;
			s_q.pwm_base <= 8'h00;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs; pin follows the port latch unless compare owns it
	assign reg_rdata = s_q.rdata;
	assign unit_event_flag = s_q.flag;
	assign compare_match = s_q.match;
	assign event_pin_out = ccu_pkg::ccu_drives_pin(mode) ? s_q.cmp_latch :
		port_latch;
	assign event_pin_oe = pin_dir_output;
	assign pwm_active = s_q.pwm_on;
	assign pwm_duty = s_q.duty;
	assign pwm_timebase = s_q.pwm_base;

endmodule

// >>> dv/ccu_far_model.sv
// Far-side model: the four timers that feed the unit
`timescale 1ns/1ps
module ccu_far_model (
	input wire logic clock,
	output logic [15:0] timer_one_count,
	output logic [15:0] timer_three_count,
	output logic [7:0] pwm_timer_two_count,
	output logic [7:0] pwm_timer_four_count
);
	// Start values are arbitrary; timer one wraps early on purpose.
	// One process owns the counts, so each has a single driver.
	// Synchronous stepping only; one counts down so selection shows
	initial begin
		timer_one_count = 16'hfff0;
		timer_three_count = 16'h0010;
		pwm_timer_two_count = 8'h00;
		pwm_timer_four_count = 8'h80;
		forever @(posedge clock) begin
			timer_one_count <= timer_one_count + 16'h0001;
			timer_three_count <= timer_three_count - 16'h0001;
			pwm_timer_two_count <= pwm_timer_two_count + 8'h01;
			pwm_timer_four_count <= pwm_timer_four_count + 8'h02;
		end
	end
endmodule

// >>> dv/ccu_unit_sva.sv
// Checker of register, flag and pin relations of the unit
`timescale 1ns/1ps
module ccu_unit_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic flag_clear,
	input wire logic unit_event_flag,
	input wire logic compare_match,
	input wire logic port_latch,
	input wire logic event_pin_out,
	input wire logic pwm_active,
	input wire logic [9:0] pwm_duty
);
	logic [3:0] mode_q;
	logic cw;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	assign cw = reg_write && reg_addr == 2'h0;
	// Shadow of the mode field, so checks can be mode-qualified
	always_ff @(posedge clock) begin
		mode_q <= !rst_n ? 4'h0 : (cw ? reg_wdata[3:0] : mode_q);
	end
	// Entry into a mode from a different one
	sequence s_enter(logic [3:0] m);
		cw && reg_wdata[3:0] == m && mode_q != m;
	endsequence
	property p_top0;
		reg_read && reg_addr == 2'h0 |=> reg_rdata[7:6] == 2'h0;
	endproperty
	a_top0: assert property (p_top0) else $error("top bits set");
	property p_sticky;
		unit_event_flag && !flag_clear |=> unit_event_flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_mflag;
		compare_match |-> unit_event_flag;
	endproperty
	a_mflag: assert property (p_mflag) else $error("no flag");
	property p_rsv;
		mode_q inside {4'h0, 4'h1, 4'h3, 4'hb} && $stable(mode_q)
			|-> !compare_match;
	endproperty
	a_rsv: assert property (p_rsv) else $error("idle match");
	property p_soft;
		mode_q == 4'ha |-> event_pin_out == port_latch;
	endproperty
	a_soft: assert property (p_soft) else $error("pin taken");
	property p_low;
		s_enter(4'h8) |=> !event_pin_out;
	endproperty
	a_low: assert property (p_low) else $error("not low");
	property p_high;
		s_enter(4'h9) |=> event_pin_out;
	endproperty
	a_high: assert property (p_high) else $error("not high");
	property p_tgl;
		compare_match && mode_q == 4'h2 && $past(mode_q) == 4'h2
			|-> event_pin_out != $past(event_pin_out);
	endproperty
	a_tgl: assert property (p_tgl) else $error("no toggle");
	property p_pwm;
		cw && reg_wdata[3:2] == 2'h3 ##1 1'b1 [*2]
			|-> pwm_active && pwm_duty[1:0] == $past(reg_wdata[5:4], 2);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm bits");
endmodule
bind ccu_unit ccu_unit_chk chk_u (.clock, .rst_n, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .flag_clear, .unit_event_flag,
	.compare_match, .port_latch, .event_pin_out, .pwm_active, .pwm_duty);

// >>> dv/capture_compare_pwm_unit_test.sv
// Self-checking bench of the capture/compare unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	cmp_count++; \
	if ((e) !== (g)) begin \
		num_errors++; \
		$display("wrong value %s exp %h got %h", n, e, g); \
	end \
end
module capture_compare_pwm_unit_test;
	logic clock = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d, r;
	logic [15:0] timer_one_count, timer_three_count, tv;
	logic [7:0] pwm_timer_two_count, pwm_timer_four_count, pwm_timebase;
	logic cc_use_timer_three = 1'b0, pwm_use_timer_four = 1'b0;
	logic flag_clear = 1'b0;
	logic event_pin_in = 1'b0, port_latch = 1'b0, pin_dir_output = 1'b0;
	logic unit_event_flag, compare_match, event_pin_out, event_pin_oe;
	logic pwm_active, eb, ea;
	logic [9:0] pwm_duty;
	logic [3:0] m;
	// Set-high first, so the zero write before toggle has a latch to clear
	logic [3:0] cm[4] = '{4'h8, 4'h2, 4'h9, 4'ha};
	logic [3:0] rs[3] = '{4'h1, 4'h3, 4'hb};
	logic [15:0] capq[$];
	int num_errors = 0, cmp_count = 0, seed = 36, cyc = 0, n, i, c0;
	always #20 clock = ~clock;
	ccu_far_model far_u (.clock, .timer_one_count, .timer_three_count,
		.pwm_timer_two_count, .pwm_timer_four_count);
	ccu_unit dut_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .timer_one_count, .timer_three_count,
		.cc_use_timer_three, .pwm_timer_two_count, .pwm_timer_four_count,
		.pwm_use_timer_four, .flag_clear, .unit_event_flag, .compare_match,
		.event_pin_in, .port_latch, .pin_dir_output, .event_pin_out,
		.event_pin_oe, .pwm_active, .pwm_duty, .pwm_timebase);
	task automatic results();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Cut a hang short well past the expected run length
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			results();
		end
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic clr();
		@(posedge clock);
		flag_clear <= 1'b1;
		@(posedge clock);
		flag_clear <= 1'b0;
	endtask
	// Pin level held three cycles; model notes the capture it expects
	task automatic pin(input logic v);
		@(posedge clock);
		event_pin_in <= v;
		#1 tv = cc_use_timer_three ? timer_three_count - 16'h0003
			: timer_one_count + 16'h0003;
		n += v;
		if ((m == 4'h4 && !v) || (m == 4'h5 && v) ||
			(m == 4'h6 && v && n % 4 == 0) || (m == 4'h7 && v && n % 16 == 0))
			capq.push_back(tv);
		repeat (2) @(posedge clock);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1 `CHK("reset", 29'h0, {unit_event_flag, compare_match, pwm_active,
			pwm_duty, pwm_timebase, reg_rdata})
		`CHK("reset pin", port_latch, event_pin_out)
		// Random traffic to every slot, the unmapped one included
		for (i = 0; i < 12; i++) begin
			d = 8'($random(seed));
			wr(2'(i % 4), d);
			rd(2'(i % 4), r);
			`CHK("reg", i % 4 == 3 ? 8'h00 : (i % 4 == 0 ? d & 8'h3f : d), r)
		end
		// Each capture code entered from off; only the last value stays
		for (i = 4; i < 8; i++) begin
			m = 4'(i);
			wr(2'h0, 8'h00);
			cc_use_timer_three <= i[0];
			pin_dir_output <= (i == 7);
			wr(2'h0, {4'h0, m});
			clr();
			n = 0;
			capq = {};
			repeat (17) begin
				pin(1'b1);
				pin(1'b0);
			end
			repeat (3) @(posedge clock);
			#1 `CHK("cap flag", 1'b1, unit_event_flag)
			`CHK("cap oe", 1'(i == 7), event_pin_oe)
			rd(2'h1, r);
			`CHK("cap low", capq[$][7:0], r)
			rd(2'h2, r);
			`CHK("cap high", capq[$][15:8], r)
			clr();
			#1 `CHK("flag clear", 1'b0, unit_event_flag)
		end
		// Compare codes: target 60 cycles ahead of the chosen timer
		foreach (cm[j]) begin
			m = cm[j];
			port_latch <= 1'($random(seed));
			pin_dir_output <= 1'b1;
			cc_use_timer_three <= 1'($random(seed));
			wr(2'h0, 8'h00);
			#1 c0 = cyc;
			tv = cc_use_timer_three ? timer_three_count - 16'h003c
				: timer_one_count + 16'h003c;
			wr(2'h1, tv[7:0]);
			wr(2'h2, tv[15:8]);
			wr(2'h0, {4'h0, m});
			clr();
			eb = m == 4'h9 ? 1'b1 : (m == 4'ha ? port_latch : 1'b0);
			ea = m == 4'ha ? port_latch : (m != 4'h9);
			#1 `CHK("pin start", eb, event_pin_out)
			n = 0;
			while (compare_match !== 1'b1 && n < 100) begin
				@(posedge clock);
				#1 n++;
			end
			`CHK("match time", c0 + 61, cyc)
			`CHK("match flag", 1'b1, unit_event_flag)
			`CHK("pin end", ea, event_pin_out)
			`CHK("pin oe", 1'b1, event_pin_oe)
		end
		// Reserved codes: the timer runs through the data value, 16
		// cycles ahead, and must leave flag and pin alone
		foreach (rs[k]) begin
			wr(2'h0, 8'h00);
			#1 tv = cc_use_timer_three ? timer_three_count - 16'h0010
				: timer_one_count + 16'h0010;
			wr(2'h1, tv[7:0]);
			wr(2'h2, tv[15:8]);
			wr(2'h0, {4'h0, rs[k]});
			clr();
			repeat (20) @(posedge clock);
			#1 `CHK("rsv flag", 1'b0, unit_event_flag)
			`CHK("rsv pin", port_latch, event_pin_out)
		end
		// PWM codes hand out duty and the chosen 8-bit time base
		for (i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			pwm_use_timer_four <= i[0];
			wr(2'h1, d);
			wr(2'h0, {2'h0, 2'(i), 2'h3, 2'(i)});
			repeat (2) @(posedge clock);
			#1 `CHK("pwm duty", {d, 2'(i)}, pwm_duty)
			`CHK("pwm base", i[0] ? pwm_timer_four_count - 8'h02
				: pwm_timer_two_count - 8'h01, pwm_timebase)
		end
		wr(2'h0, 8'h00);
		repeat (2) @(posedge clock);
		#1 `CHK("pwm off", 11'h000, {pwm_active, pwm_duty})
		results();
	end
endmodule
